// ==== flash_host.sv ====
// Wishbone-controlled host that drives a byte-wide flash through its pins.
// Assumes a classic Wishbone master and a flash whose inputs are asynchronous.
//
// How it works
// - Host masks reserved bit 0 when polling.
// - Other bits ignored until ready reads one.
// - Erase is 20H then D0H, block address.
// - FFH returns flash to array reads.
// - Lock is 60H then 01H or F1H.
// - Host clears status before any retry.
//
// The placing of the registers and register access over Wishbone were decided locally.
`timescale 1ns/1ns
`default_nettype none
module flash_host (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [3:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    output flash_host_pkg::flash_drive_t flash_o,
    input wire logic [7:0] flash_data_i,
    input wire logic ready_busy_out_i
);

    // ********************************
    // State and storage
    // ********************************
    typedef enum logic [2:0] {S_IDLE, S_WR_LOW, S_WR_HIGH, S_RD_LOW, S_RD_HIGH} state_t;

    state_t state;
    logic [3:0] cnt;
    logic [2:0] op;
    logic phase;
    logic [7:0] status_byte;
    logic err_pending;
    logic refused;
    logic powerdown;
    logic [19:0] addr;
    logic [7:0] data_sync;
    logic ready_sync;

    // Pin inputs pass two flip-flops first
    pin_sync #(.W(9)) u_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .d_i({ready_busy_out_i, flash_data_i}),
        .q_o({ready_sync, data_sync})
    );

    // ********************************
    // Bus decode
    // ********************************
    wire bus_req = cyc_i && stb_i;
    wire bus_wr = bus_req && we_i && ack_o;
    wire hit_cmd = adr_i == flash_host_pkg::REG_CMD;
    wire hit_addr = adr_i == flash_host_pkg::REG_ADDR;
    wire hit_status = adr_i == flash_host_pkg::REG_STATUS;
    wire hit_ctrl = adr_i == flash_host_pkg::REG_CTRL;
    wire [31:0] lane_mask = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
    wire [19:0] next_addr = (addr & ~lane_mask[19:0]) | (dat_i[19:0] & lane_mask[19:0]);
    wire [2:0] req_op = dat_i[2:0];
    wire start_req = bus_wr && hit_cmd && sel_i[0];

    // ********************************
    // Request screening
    // ********************************
    wire op_known = req_op >= flash_host_pkg::OP_ERASE
                    && req_op <= flash_host_pkg::OP_READ_ARRAY;
    wire op_recovery = req_op == flash_host_pkg::OP_CLEAR
                       || req_op == flash_host_pkg::OP_READ_STATUS
                       || req_op == flash_host_pkg::OP_READ_ARRAY;
    // New work waits for a clear after any error
    wire op_allowed = op_known && (!err_pending || op_recovery);
    wire accept = start_req && state == S_IDLE && op_allowed && !powerdown;

    // ********************************
    // Command bytes per operation
    // ********************************
    wire is_erase = op == flash_host_pkg::OP_ERASE;
    wire is_lock_b = op == flash_host_pkg::OP_LOCK_BLOCK;
    wire is_lock_m = op == flash_host_pkg::OP_LOCK_MASTER;
    wire two_writes = is_erase || is_lock_b || is_lock_m;
    wire polls = two_writes || op == flash_host_pkg::OP_READ_STATUS;
    wire [7:0] second_code =
        is_erase ? flash_host_pkg::CMD_ERASE_CONFIRM :
        is_lock_b ? flash_host_pkg::CMD_LOCK_BLOCK :
        flash_host_pkg::CMD_LOCK_MASTER;
    wire [7:0] first_code_req =
        req_op == flash_host_pkg::OP_ERASE ? flash_host_pkg::CMD_ERASE_SETUP :
        req_op == flash_host_pkg::OP_LOCK_BLOCK ? flash_host_pkg::CMD_LOCK_SETUP :
        req_op == flash_host_pkg::OP_LOCK_MASTER ? flash_host_pkg::CMD_LOCK_SETUP :
        req_op == flash_host_pkg::OP_CLEAR ? flash_host_pkg::CMD_CLEAR_STATUS :
        req_op == flash_host_pkg::OP_READ_STATUS ? flash_host_pkg::CMD_READ_STATUS :
        flash_host_pkg::CMD_READ_ARRAY;

    // Status byte as sampled: reserved bit dropped, rest kept only when ready
    wire sampled_ready = data_sync[flash_host_pkg::SR_READY];
    wire [7:0] next_status = sampled_ready ? {data_sync[7:1], 1'b0} : 8'h00;
    wire status_err = status_byte[flash_host_pkg::SR_ERASE_ERR]
                      || status_byte[flash_host_pkg::SR_PROG_ERR]
                      || status_byte[flash_host_pkg::SR_SUPPLY]
                      || status_byte[flash_host_pkg::SR_PROTECT];
    wire cnt_pulse_end = cnt == 4'(flash_host_pkg::PULSE_CYC - 1);
    wire cnt_read_end = cnt == 4'(flash_host_pkg::READ_CYC - 1);
    wire clear_done = state == S_WR_HIGH && op == flash_host_pkg::OP_CLEAR;

    // ********************************
    // Wishbone slave
    // ********************************
    wire [31:0] status_word = {20'h00000, refused, err_pending, ready_sync,
                               state != S_IDLE, status_byte};
    wire [31:0] read_word =
        hit_cmd ? {29'h00000000, op} :
        hit_addr ? {12'h000, addr} :
        hit_status ? status_word :
        hit_ctrl ? {31'h00000000, powerdown} :
        32'h00000000;

    // Ack one cycle after the request, read data registered with it
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_o <= 1'b0;
            dat_o <= 32'h00000000;
        end
        else
        begin
            ack_o <= bus_req && !ack_o;
            dat_o <= read_word;
        end
    end

    // Software registers take writes on the ack edge
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            addr <= flash_host_pkg::ADDR_RESET;
            powerdown <= 1'b0;
        end
        else
        begin
            if (bus_wr && hit_addr)
                addr <= next_addr;
            if (bus_wr && hit_ctrl && sel_i[0])
                powerdown <= dat_i[flash_host_pkg::CTRL_PD_BIT];
        end
    end

    // Sticky error and refusal flags; a set wins over a clear
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            err_pending <= 1'b0;
            refused <= 1'b0;
        end
        else
        begin
            if (state == S_RD_HIGH && status_byte[flash_host_pkg::SR_READY] && status_err)
                err_pending <= 1'b1;
            else if (clear_done)
                err_pending <= 1'b0;
            if (start_req && !accept)
                refused <= 1'b1;
            else if (accept)
                refused <= 1'b0;
        end
    end

    // ********************************
    // Pin sequencer
    // ********************************
    // Each write pulses chip enable and write enable with data held a cycle
    // past the rising edge; polls repeat until the ready bit reads one.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state <= S_IDLE;
            cnt <= 4'h0;
            op <= flash_host_pkg::OP_READ_ARRAY;
            phase <= 1'b0;
            status_byte <= flash_host_pkg::STATUS_RESET;
            flash_o <= '{addr: 20'h00000, data: 8'h00, data_oe: 1'b0, ce_n: 1'b1,
                         we_n: 1'b1, oe_n: 1'b1, rp_n: 1'b0};
        end
        else
        begin
            flash_o.rp_n <= !powerdown;
            unique case (state)
                S_IDLE:
                begin
                    if (accept)
                    begin
                        op <= req_op;
                        phase <= 1'b0;
                        cnt <= 4'h0;
                        flash_o.addr <= addr;
                        flash_o.data <= first_code_req;
                        flash_o.data_oe <= 1'b1;
                        flash_o.ce_n <= 1'b0;
                        flash_o.we_n <= 1'b0;
                        state <= S_WR_LOW;
                    end
                end
                S_WR_LOW:
                begin
                    cnt <= cnt + 4'h1;
                    if (cnt_pulse_end)
                    begin
                        flash_o.ce_n <= 1'b1;
                        flash_o.we_n <= 1'b1;
                        state <= S_WR_HIGH;
                    end
                end
                S_WR_HIGH:
                begin
                    cnt <= 4'h0;
                    if (two_writes && !phase)
                    begin
                        // Confirm byte goes to the same held address
                        phase <= 1'b1;
                        flash_o.data <= second_code;
                        flash_o.ce_n <= 1'b0;
                        flash_o.we_n <= 1'b0;
                        state <= S_WR_LOW;
                    end
                    else
                    begin
                        flash_o.data_oe <= 1'b0;
                        if (polls)
                        begin
                            flash_o.ce_n <= 1'b0;
                            flash_o.oe_n <= 1'b0;
                            state <= S_RD_LOW;
                        end
                        else
                            state <= S_IDLE;
                    end
                end
                S_RD_LOW:
                begin
                    cnt <= cnt + 4'h1;
                    if (cnt_read_end)
                    begin
                        status_byte <= next_status;
                        flash_o.ce_n <= 1'b1;
                        flash_o.oe_n <= 1'b1;
                        state <= S_RD_HIGH;
                    end
                end
                S_RD_HIGH:
                begin
                    cnt <= 4'h0;
                    if (status_byte[flash_host_pkg::SR_READY])
                        state <= S_IDLE;
                    else
                    begin
                        flash_o.ce_n <= 1'b0;
                        flash_o.oe_n <= 1'b0;
                        state <= S_RD_LOW;
                    end
                end
            endcase
        end
    end

    // ********************************
    // Checks
    // ********************************
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    a_reserved_masked: assert property (!status_byte[flash_host_pkg::SR_RSVD])
        else $error("reserved status bit kept");
    a_busy_hides_bits: assert property (
        !status_byte[flash_host_pkg::SR_READY] |-> status_byte[6:0] == 7'h00)
        else $error("status bits kept while busy");
    a_erase_setup: assert property (
        state == S_IDLE && accept && req_op == flash_host_pkg::OP_ERASE
        |=> flash_o.data == 8'h20 && !flash_o.we_n && flash_o.data_oe)
        else $error("erase setup byte wrong");
    a_erase_confirm: assert property (
        $rose(phase) && is_erase |-> flash_o.data == 8'hD0 && !flash_o.we_n
        && flash_o.addr == $past(flash_o.addr))
        else $error("erase confirm byte wrong");
    a_lock_confirm: assert property (
        $rose(phase) && (is_lock_b || is_lock_m) |-> $past(flash_o.data) == 8'h60
        && flash_o.data == (is_lock_b ? 8'h01 : 8'hF1))
        else $error("lock sequence wrong");
    a_array_byte: assert property (
        accept && req_op == flash_host_pkg::OP_READ_ARRAY
        |=> flash_o.data == 8'hFF ##1 flash_o.we_n ##1 state == S_IDLE)
        else $error("read array sequence wrong");
    a_retry_blocked: assert property (
        start_req && err_pending && req_op == flash_host_pkg::OP_ERASE
        |=> refused && state == $past(state))
        else $error("retry taken before clear");
    a_poll_ends_ready: assert property (
        state == S_RD_HIGH && status_byte[flash_host_pkg::SR_READY] |=> state == S_IDLE)
        else $error("poll did not stop at ready");
    a_no_contention: assert property (!(flash_o.data_oe && !flash_o.oe_n))
        else $error("data driven during read");

    c_erase_done: cover property (
        state == S_RD_HIGH && is_erase && status_byte[flash_host_pkg::SR_READY]);
    c_poll_repeat: cover property (
        state == S_RD_HIGH && !status_byte[flash_host_pkg::SR_READY]);
    c_refused: cover property ($rose(refused));
    c_cleared: cover property (clear_done && err_pending);

endmodule
`default_nettype wire

// ==== flash_host_bench.sv ====
// Self-checking bench: flash host controller against a behavioural flash.
// Assumes the Wishbone answer and pin timing given for the controller.
`timescale 1ns/1ns
`default_nettype none
module flash_host_bench;
    logic clk_i;
    logic rst_i;
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] adr;
    logic [31:0] dat_w;
    logic [31:0] dat_r;
    logic ack;
    flash_host_pkg::flash_drive_t pins;
    wire logic [7:0] fl_data;
    wire logic [7:0] bus = pins.data_oe ? pins.data : fl_data;
    logic ready_pin;
    logic supply_ok;
    logic rp_hv;
    logic bad_seq;
    logic [15:0] busy_ns;
    logic [31:0] st;
    logic [19:0] a;
    int err_count;
    int samples_checked;

    flash_host flash_host_inst (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb),
        .we_i(we), .adr_i(adr), .sel_i(4'hF), .dat_i(dat_w), .dat_o(dat_r), .ack_o(ack),
        .flash_o(pins), .flash_data_i(bus), .ready_busy_out_i(ready_pin));
    flash_model flash_model_inst (.pins_i(pins), .bus_i(bus), .supply_ok_i(supply_ok),
        .rp_hv_i(rp_hv), .bad_seq_i(bad_seq), .busy_ns_i(busy_ns), .data_o(fl_data),
        .ready_o(ready_pin));

    // ************************************
    // Clock, checks and bus tasks
    // ************************************
    initial
    begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            err_count++;
            $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    // Status word once the sequencer is idle
    function automatic logic [31:0] exp_st(input logic [7:0] flags, input logic refused);
        exp_st = {20'h00000, refused, |(flags & 8'h3A), 2'b10, 8'h80 | flags};
    endfunction

    // One classic Wishbone cycle; read data lands in st
    task automatic wb(input logic w, input logic [3:0] ad, input logic [31:0] d);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= ad;
        dat_w <= d;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (ack !== 1'b1 && n < 20);
        if (n >= 20)
            err_count++;
        st = dat_r;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic start_op(input logic [2:0] op, input logic [19:0] ad);
        wb(1'b1, flash_host_pkg::REG_ADDR, {12'h000, ad});
        wb(1'b1, flash_host_pkg::REG_CMD, {29'h00000000, op});
    endtask

    task automatic wait_idle();
        int n;
        n = 0;
        do
        begin
            wb(1'b0, flash_host_pkg::REG_STATUS, 32'h00000000);
            n++;
        end
        while (st[8] !== 1'b0 && n < 3000);
        if (n >= 3000)
            err_count++;
    endtask

    task automatic run_op(input logic [2:0] op, input logic [19:0] ad, input logic [7:0] flags);
        start_op(op, ad);
        wait_idle();
        check(st, exp_st(flags, 1'b0));
    endtask

    task automatic clear_err();
        start_op(flash_host_pkg::OP_CLEAR, 20'h00000);
        wait_idle();
        run_op(flash_host_pkg::OP_READ_STATUS, 20'h00000, 8'h00);
    endtask

    task automatic check_log(input logic [19:0] ad, input logic [7:0] c0, input logic [7:0] c1);
        check({4'h0, flash_model_inst.cmd_log[$-1]}, {4'h0, ad, c0});
        check({4'h0, flash_model_inst.cmd_log[$]}, {4'h0, ad, c1});
    endtask

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // Hang guard, far beyond the expected run
    initial
    begin
        #5000000;
        err_count++;
        give_verdict();
    end

    // ************************************
    // Test sequence
    // ************************************
    initial
    begin
        void'($urandom(32'h76F9));
        rst_i = 1'b1;
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = 4'h0;
        dat_w = 32'h00000000;
        supply_ok = 1'b1;
        rp_hv = 1'b0;
        bad_seq = 1'b0;
        busy_ns = 16'h012C;
        repeat (4) @(posedge clk_i);
        check({28'h0000000, pins.ce_n, pins.we_n, pins.oe_n, pins.data_oe}, 32'h0000000E);
        rst_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        wb(1'b0, flash_host_pkg::REG_STATUS, 32'h00000000);
        check(st, 32'h00000200);
        wb(1'b1, 4'h2, 32'hFFFFFFFF);
        wb(1'b0, 4'h2, 32'h00000000);
        check(st, 32'h00000000);
        run_op(flash_host_pkg::OP_READ_STATUS, 20'h00000, 8'h00);
        $display("test reset done");
        repeat (6)
        begin
            a = 20'($urandom);
            busy_ns <= 16'($urandom_range(3000, 100));
            run_op(flash_host_pkg::OP_ERASE, a, 8'h00);
            check_log(a, flash_host_pkg::CMD_ERASE_SETUP,
                flash_host_pkg::CMD_ERASE_CONFIRM);
            check({31'h00000000, flash_model_inst.status_mode}, 32'h00000001);
        end
        $display("test erase done");
        busy_ns <= 16'h1770;
        start_op(flash_host_pkg::OP_ERASE, 20'h10000);
        repeat (10) @(posedge clk_i);
        wb(1'b0, flash_host_pkg::REG_STATUS, 32'h00000000);
        check({30'h00000000, st[9:8]}, 32'h00000001);
        wait_idle();
        check(st, exp_st(8'h00, 1'b0));
        busy_ns <= 16'h0190;
        $display("test busy done");
        run_op(flash_host_pkg::OP_LOCK_BLOCK, 20'h30000, 8'h00);
        check_log(20'h30000, flash_host_pkg::CMD_LOCK_SETUP,
            flash_host_pkg::CMD_LOCK_BLOCK);
        run_op(flash_host_pkg::OP_ERASE, 20'h3ABCD, 8'h22);
        run_op(flash_host_pkg::OP_READ_STATUS, 20'h00000, 8'h22);
        start_op(flash_host_pkg::OP_ERASE, 20'h00000);
        wb(1'b0, flash_host_pkg::REG_STATUS, 32'h00000000);
        check(st, exp_st(8'h22, 1'b1));
        clear_err();
        $display("test protect done");
        run_op(flash_host_pkg::OP_LOCK_MASTER, 20'h12345, 8'h12);
        clear_err();
        rp_hv <= 1'b1;
        run_op(flash_host_pkg::OP_LOCK_MASTER, 20'h12345, 8'h00);
        check_log(20'h12345, flash_host_pkg::CMD_LOCK_SETUP,
            flash_host_pkg::CMD_LOCK_MASTER);
        rp_hv <= 1'b0;
        run_op(flash_host_pkg::OP_LOCK_BLOCK, 20'h50000, 8'h12);
        clear_err();
        rp_hv <= 1'b1;
        run_op(flash_host_pkg::OP_LOCK_BLOCK, 20'h50000, 8'h00);
        run_op(flash_host_pkg::OP_ERASE, 20'h50000, 8'h00);
        rp_hv <= 1'b0;
        $display("test lock done");
        supply_ok <= 1'b0;
        run_op(flash_host_pkg::OP_ERASE, 20'h20000, 8'h28);
        clear_err();
        run_op(flash_host_pkg::OP_LOCK_BLOCK, 20'h60000, 8'h18);
        clear_err();
        supply_ok <= 1'b1;
        run_op(flash_host_pkg::OP_ERASE, 20'h20000, 8'h00);
        bad_seq <= 1'b1;
        run_op(flash_host_pkg::OP_ERASE, 20'h70000, 8'h30);
        clear_err();
        bad_seq <= 1'b0;
        $display("test faults done");
        start_op(flash_host_pkg::OP_READ_ARRAY, 20'h00000);
        wait_idle();
        check({31'h00000000, flash_model_inst.status_mode}, 32'h00000000);
        wb(1'b1, flash_host_pkg::REG_CTRL, 32'h00000001);
        repeat (4) @(posedge clk_i);
        check({31'h00000000, pins.rp_n}, 32'h00000000);
        wb(1'b0, flash_host_pkg::REG_STATUS, 32'h00000000);
        check({31'h00000000, st[9]}, 32'h00000001);
        start_op(flash_host_pkg::OP_ERASE, 20'h00000);
        wb(1'b0, flash_host_pkg::REG_STATUS, 32'h00000000);
        check({31'h00000000, st[11]}, 32'h00000001);
        wb(1'b1, flash_host_pkg::REG_CTRL, 32'h00000000);
        run_op(flash_host_pkg::OP_READ_STATUS, 20'h00000, 8'h00);
        $display("test powerdown done");
        give_verdict();
    end
endmodule
`default_nettype wire

// ==== flash_host_pkg.sv ====
// Shared constants and types for the flash host controller.
// Assumes a 10 MHz system clock and a byte-wide flash on plain pins.
`default_nettype none
package flash_host_pkg;

    // ********************************
    // Register map (byte offsets)
    // ********************************
    localparam logic [3:0] REG_CMD = 4'h0;
    localparam logic [3:0] REG_ADDR = 4'h4;
    localparam logic [3:0] REG_STATUS = 4'h8;
    localparam logic [3:0] REG_CTRL = 4'hC;

    // Status register field positions
    localparam int ST_BYTE_LSB = 0;
    localparam int ST_BUSY_BIT = 8;
    localparam int ST_PIN_BIT = 9;
    localparam int ST_ERR_BIT = 10;
    localparam int ST_REFUSED_BIT = 11;
    localparam int CTRL_PD_BIT = 0;
    localparam logic [19:0] ADDR_RESET = 20'h00000;
    localparam logic [7:0] STATUS_RESET = 8'h00;

    // ********************************
    // Operations software can order
    // ********************************
    localparam logic [2:0] OP_ERASE = 3'h1;
    localparam logic [2:0] OP_LOCK_BLOCK = 3'h2;
    localparam logic [2:0] OP_LOCK_MASTER = 3'h3;
    localparam logic [2:0] OP_CLEAR = 3'h4;
    localparam logic [2:0] OP_READ_STATUS = 3'h5;
    localparam logic [2:0] OP_READ_ARRAY = 3'h6;

    // ********************************
    // Flash command bytes
    // ********************************
    localparam logic [7:0] CMD_ERASE_SETUP = 8'h20;
    localparam logic [7:0] CMD_ERASE_CONFIRM = 8'hD0;
    localparam logic [7:0] CMD_LOCK_SETUP = 8'h60;
    localparam logic [7:0] CMD_LOCK_BLOCK = 8'h01;
    localparam logic [7:0] CMD_LOCK_MASTER = 8'hF1;
    localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
    localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
    localparam logic [7:0] CMD_READ_STATUS = 8'h70;

    // Flash status byte bit positions
    localparam int SR_READY = 7;
    localparam int SR_ERASE_ERR = 5;
    localparam int SR_PROG_ERR = 4;
    localparam int SR_SUPPLY = 3;
    localparam int SR_PROTECT = 1;
    localparam int SR_RSVD = 0;

    // ********************************
    // Pin timing
    // ********************************
    localparam int CLK_NS = 100;
    localparam int PULSE_NS = 100;
    localparam int ACCESS_NS = 100;
    localparam int SYNC_STAGES = 2;
    localparam int PULSE_CYC = (PULSE_NS + CLK_NS - 1) / CLK_NS;
    localparam int ACCESS_CYC = (ACCESS_NS + CLK_NS - 1) / CLK_NS;
    localparam int READ_CYC = ACCESS_CYC + SYNC_STAGES + 1;

    // Everything the controller drives toward the flash
    typedef struct packed {
        logic [19:0] addr;
        logic [7:0] data;
        logic data_oe;
        logic ce_n;
        logic we_n;
        logic oe_n;
        logic rp_n;
    } flash_drive_t;

endpackage
`default_nettype wire

// ==== flash_model.sv ====
// Behavioural byte-wide flash: status flags, erase and lock-bit sequences.
// Assumes the bench resolves the data bus and drives the fault inputs.
`timescale 1ns/1ns
`default_nettype none
module flash_model (
    input wire flash_host_pkg::flash_drive_t pins_i,
    input wire logic [7:0] bus_i,
    input wire logic supply_ok_i,
    input wire logic rp_hv_i,
    input wire logic bad_seq_i,
    input wire logic [15:0] busy_ns_i,
    output logic [7:0] data_o,
    output logic ready_o
);
    logic [7:0] sr;
    logic [7:0] setup;
    logic [7:0] fail;
    logic [7:0] ebit;
    logic [7:0] noise;
    logic [3:0] blk;
    logic status_mode;
    logic busy;
    logic master_lock;
    logic [15:0] block_lock;
    logic [27:0] cmd_log [$];
    wire logic reading = !pins_i.ce_n && !pins_i.oe_n && pins_i.rp_n;
    // A write ends at whichever strobe rises first; both may rise together
    wire logic write_strobe_n = pins_i.ce_n || pins_i.we_n;
    wire logic [7:0] status_byte = busy ? {1'b0, noise[6:0]} : {1'b1, sr[6:1], noise[0]};

    // Read path; an undriven bus shows a moving pattern
    assign data_o = !reading ? noise : (status_mode ? status_byte : pins_i.addr[7:0]);
    // Ready pin is low only while the engine works
    assign ready_o = !busy;

    // Power-up state
    initial
    begin
        noise = 8'hA5;
        master_lock = 1'b0;
        block_lock = 16'h0000;
        busy = 1'b0;
        sr = 8'h00;
        setup = 8'h00;
        status_mode = 1'b0;
    end

    always #50 noise = noise + 8'h3B;

    // Reset pin low returns to read array with clean flags
    always @(negedge pins_i.rp_n)
    begin
        sr = 8'h00;
        setup = 8'h00;
        status_mode = 1'b0;
    end

    // Command writes latch when the combined write strobe rises
    always @(posedge write_strobe_n)
    begin
        if (pins_i.rp_n && !busy)
        begin
            cmd_log.push_back({pins_i.addr, bus_i});
            blk = pins_i.addr[19:16];
            if (setup != 8'h00)
            begin
                fail = 8'h00;
                ebit = (setup == flash_host_pkg::CMD_ERASE_SETUP) ? 8'h20 : 8'h10;
                if (bad_seq_i || !((setup == flash_host_pkg::CMD_ERASE_SETUP
                    && bus_i == flash_host_pkg::CMD_ERASE_CONFIRM)
                    || (setup == flash_host_pkg::CMD_LOCK_SETUP
                    && (bus_i == flash_host_pkg::CMD_LOCK_BLOCK
                    || bus_i == flash_host_pkg::CMD_LOCK_MASTER))))
                    fail = 8'h30;
                else if (!supply_ok_i)
                    fail = ebit | 8'h08;
                else if (!rp_hv_i && (ebit == 8'h20 ? block_lock[blk] :
                    (bus_i == flash_host_pkg::CMD_LOCK_BLOCK ? master_lock : 1'b1)))
                    fail = ebit | 8'h02;
                else if (bus_i == flash_host_pkg::CMD_LOCK_BLOCK)
                    block_lock[blk] = 1'b1;
                else if (bus_i == flash_host_pkg::CMD_LOCK_MASTER)
                    master_lock = 1'b1;
                setup = 8'h00;
                busy = 1'b1;
                #(busy_ns_i);
                sr = sr | fail;
                busy = 1'b0;
            end
            else if (bus_i == flash_host_pkg::CMD_ERASE_SETUP || bus_i == flash_host_pkg::CMD_LOCK_SETUP)
            begin
                setup = bus_i;
                status_mode = 1'b1;
            end
            else if (bus_i == flash_host_pkg::CMD_CLEAR_STATUS)
                sr = 8'h00;
            else
                status_mode = (bus_i != flash_host_pkg::CMD_READ_ARRAY);
        end
    end
endmodule
`default_nettype wire

// ==== pin_sync.sv ====
// Two-stage synchroniser for pin inputs.
// Assumes the inputs are asynchronous to clk_i.
`timescale 1ns/1ns
`default_nettype none
module pin_sync #(
    parameter int W = 1
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] meta;

    // First stage feeds only the second
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            meta <= '0;
            q_o <= '0;
        end
        else
        begin
            meta <= d_i;
            q_o <= meta;
        end
    end
endmodule
`default_nettype wire
